/* File: common/adc_ctrl_pkg.sv */
// Constants for the converter control block: register map, fields, codes
// Assumes an 8-bit register bus with a 3-bit byte address
package adc_ctrl_pkg;
    // Register offsets
    localparam logic [2:0] OFS_CTRL1 = 3'h0;
    localparam logic [2:0] OFS_CTRL2 = 3'h1;
    localparam logic [2:0] OFS_RESH = 3'h2;
    localparam logic [2:0] OFS_RESL = 3'h3;
    localparam logic [2:0] OFS_CMPH = 3'h4;
    localparam logic [2:0] OFS_CMPL = 3'h5;
    localparam logic [2:0] OFS_CFG = 3'h6;
    // Field positions
    localparam int DONE_BIT = 7;
    localparam int IRQEN_BIT = 6;
    localparam int CONT_BIT = 5;
    localparam int ACTIVE_BIT = 7;
    localparam int HWTRIG_BIT = 6;
    localparam int CMPEN_BIT = 5;
    localparam int CMPGE_BIT = 4;
    localparam int LOWPWR_BIT = 7;
    localparam int DIV_LSB = 5;
    localparam int LONG_BIT = 4;
    localparam int RES10_BIT = 2;
    localparam int SRC_LSB = 0;
    // Reset values
    localparam logic [7:0] CTRL1_RST = 8'h1f;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [9:0] CMP_RST = 10'h000;
    // Channel codes
    localparam int NUM_PINS = 12;
    localparam logic [4:0] CH_GND_FIRST = 5'h0c;
    localparam logic [4:0] CH_GND_LAST = 5'h14;
    localparam logic [4:0] CH_TEMP = 5'h1a;
    localparam logic [4:0] CH_BG = 5'h1b;
    localparam logic [4:0] CH_REFH = 5'h1d;
    localparam logic [4:0] CH_REFL = 5'h1e;
    localparam logic [4:0] CH_OFF = 5'h1f;
    // Power modes and clock sources
    localparam logic [1:0] PM_RUN = 2'h0;
    localparam logic [1:0] PM_WAIT = 2'h1;
    localparam logic [1:0] PM_STOP3 = 2'h2;
    localparam logic [1:0] PM_STOP2 = 2'h3;
    localparam logic [1:0] SRC_BUS = 2'h0;
    localparam logic [1:0] SRC_BUS2 = 2'h1;
    localparam logic [1:0] SRC_ALT = 2'h2;
    localparam logic [1:0] SRC_ASYNC = 2'h3;
    // Timing in conversion clock ticks
    localparam logic [4:0] SAMPLE_SHORT_CYC = 5'h04;
    localparam logic [4:0] SAMPLE_LONG_CYC = 5'h18;
    localparam logic [4:0] RES_BITS = 5'h0a;
endpackage

/* File: common/conv_if.sv */
// Signals between control, conversion clock generator and SAR engine
// Assumes all three parts sit on mclk
`timescale 1ns/1ps
interface conv_if;
    logic tick;
    logic start;
    logic abort;
    logic long_sample;
    logic busy;
    logic done;
    logic [9:0] result;
    logic [9:0] dac;
    logic comp_hi;
    logic [1:0] src_sel;
    logic [1:0] div_sel;
    logic [1:0] power_mode;
    modport clkgen (input src_sel, input div_sel, input power_mode, output tick);
    modport engine (input tick, input start, input abort, input long_sample,
        input comp_hi, output busy, output done, output result, output dac);
    modport ctrl (output start, output abort, output long_sample, output comp_hi,
        output src_sel, output div_sel, output power_mode, input tick,
        input busy, input done, input result, input dac);
endinterface

/* File: rtl/adc_trigger_ctrl.sv */
// Converter control: registers, channel decode, triggers, compare, flag
// Assumes a same-clock register master and an on-chip comparator on mclk
//
// Function
// - Codes 0x00-0x0b route twelve pins, 0x0c-0x14 route ground
// - 0x1a temp, 0x1b bandgap (needs buffer enable), 0x1d high, 0x1e low ref
// - Reserved codes convert normally with undefined result
// - All-ones code powers off, isolates inputs, ends continuous without extra conversion
// - Conversion clock from bus, bus/2, alternate or local async, then divided
// - Alternate clock keeps running conversions in wait
// - Alternate clock unusable in stop states
// - Hardware mode starts a conversion on a counter overflow; overflows while one is pending merge into it
// - Overflow trigger ignores the counter interrupt enable
// - Hardware trigger works in run, wait and shallow stop
// - Software picks software start or hardware trigger
// - Ten-bit conversion, ten or eight bit right-justified result
// - Single or continuous; single returns to idle by itself
// - Optional compare, less-than or greater-or-equal, gates the flag
// - Completion flag set on finish, drives interrupt when enabled
// - Configurable sample length and speed versus power
// - Conversions continue in wait, and in shallow stop on the local async clock only
// - Control one write aborts, and restarts in software mode unless code is all ones
// - Flag clears on control one write or low result read
`timescale 1ns/1ps
module adc_trigger_ctrl
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    // System side
    input wire logic [1:0] power_mode,
    input wire logic bandgap_buffer_enable,
    input wire logic hw_trigger_input,
    input wire logic alternate_clock,
    input wire logic local_async_conv_clock,
    // Analog front end
    input wire logic comp_hi,
    output logic [9:0] dac_code,
    output logic [NUM_PINS-1:0] pin_sel,
    output logic gnd_sel,
    output logic temp_sel,
    output logic bandgap_sel,
    output logic refh_sel,
    output logic refl_sel,
    output logic conv_power,
    output logic low_power_bias,
    // Interrupt
    output logic irq
);
    conv_if cv ();

    logic [1:0] rst_pipe_ff;
    logic rst_sync_n;

    // Reset release through two stages; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_ff <= 2'b00;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe_ff[1];

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_sync_n);

    // Register state
    logic irq_en_ff, nxt_irq_en;
    logic cont_ff, nxt_cont;
    logic [4:0] ch_ff, nxt_ch;
    logic hw_mode_ff, nxt_hw_mode;
    logic cmp_en_ff, nxt_cmp_en;
    logic cmp_ge_ff, nxt_cmp_ge;
    logic [9:0] cmp_val_ff, nxt_cmp_val;
    logic [7:0] cfg_ff, nxt_cfg;
    logic [9:0] result_ff, nxt_result;
    logic done_ff, nxt_done;
    logic irq_ff, nxt_irq;
    logic [7:0] rdata_ff, nxt_rdata;

    // Trigger and start state
    logic [2:0] trig_ff, nxt_trig;
    logic pend_ff, nxt_pend;
    logic start_ff, nxt_start;

    // Decode state
    logic [NUM_PINS-1:0] pin_ff, nxt_pin;
    logic gnd_ff, nxt_gnd;
    logic temp_ff, nxt_temp;
    logic bg_ff, nxt_bg;
    logic refh_ff, nxt_refh;
    logic refl_ff, nxt_refl;
    logic power_ff, nxt_power;

    // Decoded strobes and helpers
    logic ctrl1_wr, resl_rd, run_ok, trig_edge;
    logic sw_go, hw_go, cont_go, flag_set, flag_clr, cmp_true;
    logic [4:0] ch_eff;
    logic [9:0] res_fmt;

    assign ctrl1_wr = wr_stb && (addr == OFS_CTRL1);
    assign resl_rd = rd_stb && (addr == OFS_RESL);
    // Nothing converts in the deepest stop state
    assign run_ok = power_mode != PM_STOP2;
    assign ch_eff = ctrl1_wr ? wdata[4:0] : ch_ff;
    // Stage 0 of the trigger pipe feeds only stage 1
    assign trig_edge = trig_ff[1] & ~trig_ff[2];

    // Eight-bit mode drops the two low bits and stays right-justified
    always_comb begin
        res_fmt = cfg_ff[RES10_BIT] ? cv.result : {2'b00, cv.result[9:2]};
        cmp_true = cmp_ge_ff ? (res_fmt >= cmp_val_ff) : (res_fmt < cmp_val_ff);
    end

    // Start sources; software write wins the abort it also causes
    always_comb begin
        sw_go = ctrl1_wr && !hw_mode_ff && (wdata[4:0] != CH_OFF) && run_ok;
        hw_go = pend_ff && !cv.busy && !start_ff && hw_mode_ff && (ch_eff != CH_OFF)
            && !ctrl1_wr && run_ok;
        cont_go = cv.done && cont_ff && (ch_eff != CH_OFF) && !ctrl1_wr && run_ok;
        nxt_trig = {trig_ff[1:0], hw_trigger_input};
        nxt_start = sw_go || hw_go || cont_go;
        // A pending overflow survives a busy engine; further overflows before it starts merge into it
        nxt_pend = (trig_edge && hw_mode_ff) || (pend_ff && !hw_go);
        if (!hw_mode_ff) begin
            nxt_pend = 1'b0;
        end
    end

    // Start and trigger registers
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            trig_ff <= 3'h0;
            pend_ff <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            trig_ff <= nxt_trig;
            pend_ff <= nxt_pend;
            start_ff <= nxt_start;
        end
    end

    // Software writes; reserved bits are dropped
    always_comb begin
        nxt_irq_en = irq_en_ff;
        nxt_cont = cont_ff;
        nxt_ch = ch_ff;
        nxt_hw_mode = hw_mode_ff;
        nxt_cmp_en = cmp_en_ff;
        nxt_cmp_ge = cmp_ge_ff;
        nxt_cmp_val = cmp_val_ff;
        nxt_cfg = cfg_ff;
        if (wr_stb) begin
            case (addr)
                OFS_CTRL1: begin
                    nxt_irq_en = wdata[IRQEN_BIT];
                    nxt_cont = wdata[CONT_BIT];
                    nxt_ch = wdata[4:0];
                end
                OFS_CTRL2: begin
                    nxt_hw_mode = wdata[HWTRIG_BIT];
                    nxt_cmp_en = wdata[CMPEN_BIT];
                    nxt_cmp_ge = wdata[CMPGE_BIT];
                end
                OFS_CMPH: nxt_cmp_val = {wdata[1:0], cmp_val_ff[7:0]};
                OFS_CMPL: nxt_cmp_val = {cmp_val_ff[9:8], wdata};
                OFS_CFG: nxt_cfg = {wdata[7:4], 1'b0, wdata[RES10_BIT], wdata[1:0]};
                default: nxt_cfg = cfg_ff;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_en_ff <= CTRL1_RST[IRQEN_BIT];
            cont_ff <= CTRL1_RST[CONT_BIT];
            ch_ff <= CTRL1_RST[4:0];
            hw_mode_ff <= CTRL2_RST[HWTRIG_BIT];
            cmp_en_ff <= CTRL2_RST[CMPEN_BIT];
            cmp_ge_ff <= CTRL2_RST[CMPGE_BIT];
            cmp_val_ff <= CMP_RST;
            cfg_ff <= CFG_RST;
        end else begin
            irq_en_ff <= nxt_irq_en;
            cont_ff <= nxt_cont;
            ch_ff <= nxt_ch;
            hw_mode_ff <= nxt_hw_mode;
            cmp_en_ff <= nxt_cmp_en;
            cmp_ge_ff <= nxt_cmp_ge;
            cmp_val_ff <= nxt_cmp_val;
            cfg_ff <= nxt_cfg;
        end
    end

    // Completion flag: a finish in the clearing cycle still sets it
    always_comb begin
        flag_set = cv.done && (!cmp_en_ff || cmp_true);
        flag_clr = ctrl1_wr || resl_rd;
        nxt_done = flag_set || (done_ff && !flag_clr);
        nxt_result = flag_set ? res_fmt : result_ff;
        nxt_irq = nxt_done && nxt_irq_en;
    end

    // Read port: data valid in the cycle after the strobe only
    always_comb begin
        nxt_rdata = 8'h00;
        if (rd_stb) begin
            case (addr)
                OFS_CTRL1: nxt_rdata = {done_ff, irq_en_ff, cont_ff, ch_ff};
                OFS_CTRL2: nxt_rdata = {cv.busy, hw_mode_ff, cmp_en_ff, cmp_ge_ff, 4'h0};
                OFS_RESH: nxt_rdata = {6'h00, result_ff[9:8]};
                OFS_RESL: nxt_rdata = result_ff[7:0];
                OFS_CMPH: nxt_rdata = {6'h00, cmp_val_ff[9:8]};
                OFS_CMPL: nxt_rdata = cmp_val_ff[7:0];
                OFS_CFG: nxt_rdata = cfg_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    // Status and read registers
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done_ff <= 1'b0;
            result_ff <= 10'h000;
            irq_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            done_ff <= nxt_done;
            result_ff <= nxt_result;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    // Pin routes, one per external channel code
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            assign nxt_pin[gi] = ch_ff == 5'(gi);
        end
    endgenerate

    // Internal routes; reserved codes route nothing yet still convert
    always_comb begin
        nxt_gnd = (ch_ff >= CH_GND_FIRST) && (ch_ff <= CH_GND_LAST);
        nxt_temp = ch_ff == CH_TEMP;
        nxt_bg = (ch_ff == CH_BG) && bandgap_buffer_enable;
        nxt_refh = ch_ff == CH_REFH;
        nxt_refl = ch_ff == CH_REFL;
        // Off between conversions saves power; the all-ones code keeps it off
        nxt_power = (ch_ff != CH_OFF) && (cv.busy || start_ff) && run_ok;
    end

    // Decode registers
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_ff <= '0;
            gnd_ff <= 1'b0;
            temp_ff <= 1'b0;
            bg_ff <= 1'b0;
            refh_ff <= 1'b0;
            refl_ff <= 1'b0;
            power_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
            gnd_ff <= nxt_gnd;
            temp_ff <= nxt_temp;
            bg_ff <= nxt_bg;
            refh_ff <= nxt_refh;
            refl_ff <= nxt_refl;
            power_ff <= nxt_power;
        end
    end

    // Interface drive toward the clock generator and engine
    assign cv.start = start_ff;
    // Abort in the write cycle itself, so no stale finish can follow the write
    assign cv.abort = ctrl1_wr;
    assign cv.long_sample = cfg_ff[LONG_BIT];
    assign cv.comp_hi = comp_hi;
    assign cv.src_sel = cfg_ff[SRC_LSB +: 2];
    assign cv.div_sel = cfg_ff[DIV_LSB +: 2];
    assign cv.power_mode = power_mode;

    conv_clock_gen u_clk (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .alternate_clock(alternate_clock),
        .local_async_conv_clock(local_async_conv_clock),
        .cv(cv)
    );

    sar_engine u_sar (
        .mclk(mclk),
        .rst_sync_n(rst_sync_n),
        .cv(cv)
    );

    // Outputs
    assign rdata = rdata_ff;
    assign dac_code = cv.dac;
    assign pin_sel = pin_ff;
    assign gnd_sel = gnd_ff;
    assign temp_sel = temp_ff;
    assign bandgap_sel = bg_ff;
    assign refh_sel = refh_ff;
    assign refl_sel = refl_ff;
    assign conv_power = power_ff;
    assign low_power_bias = cfg_ff[LOWPWR_BIT];
    assign irq = irq_ff;

    off_isolate_a: assert property (ch_ff == CH_OFF |=>
        (pin_sel == '0) && !gnd_sel && !temp_sel && !bandgap_sel)
        else $error("inputs routed with channel off");
    bg_gate_a: assert property (bandgap_sel |->
        $past(bandgap_buffer_enable) && $past(ch_ff) == CH_BG)
        else $error("bandgap routed without buffer enable");
    sw_restart_a: assert property ((ctrl1_wr && !hw_mode_ff && run_ok
        && wdata[4:0] != CH_OFF) |=> cv.start ##1 cv.busy)
        else $error("write did not restart conversion");
    off_no_start_a: assert property ((ctrl1_wr && wdata[4:0] == CH_OFF) |=>
        !cv.start ##1 !cv.busy)
        else $error("conversion ran after channel off");
    flag_clear_a: assert property ((resl_rd && !cv.done) |=> !done_ff)
        else $error("flag survived low result read");
    flag_set_a: assert property ((cv.done && !cmp_en_ff) |=> done_ff && irq == irq_en_ff)
        else $error("completion flag not set");
    cmp_block_a: assert property ((cv.done && cmp_en_ff && !cmp_true && !done_ff)
        |=> !done_ff)
        else $error("flag set on false compare");
    hw_start_a: assert property ((trig_edge && hw_mode_ff && !cv.busy && !pend_ff
        && !start_ff && !cv.done && ch_ff != CH_OFF && !wr_stb) ##1 (!ctrl1_wr && run_ok)
        |=> cv.start)
        else $error("overflow did not start conversion");
    res_narrow_a: assert property ((flag_set && !cfg_ff[RES10_BIT]) |=>
        result_ff[9:8] == 2'b00)
        else $error("eight-bit result not right-justified");
    single_idle_a: assert property ((cv.done && !cont_ff && !pend_ff && !wr_stb
        && !cv.start) |=> !cv.start ##1 !cv.busy)
        else $error("single conversion did not stop");
endmodule

/* File: rtl/conv_clock_gen.sv */
// Conversion clock tick: source select, power gating, divide by 1/2/4/8
// Assumes the alternate and local async clocks are far slower than mclk
`timescale 1ns/1ps
module conv_clock_gen
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    // Raw clock pins
    input wire logic alternate_clock,
    input wire logic local_async_conv_clock,
    // Control side
    conv_if.clkgen cv
);
    logic [2:0] alt_ff, nxt_alt, asy_ff, nxt_asy, cnt_ff, nxt_cnt, lim;
    logic half_ff, nxt_half, tick_ff, nxt_tick, raw, ok;

    // Source edges and divider; stage 0 of each pipe feeds only stage 1
    always_comb begin
        nxt_alt = {alt_ff[1:0], alternate_clock};
        nxt_asy = {asy_ff[1:0], local_async_conv_clock};
        nxt_half = ~half_ff;
        raw = 1'b0;
        ok = 1'b0;
        case (cv.src_sel)
            SRC_BUS: begin
                raw = 1'b1;
                ok = (cv.power_mode == PM_RUN) || (cv.power_mode == PM_WAIT);
            end
            SRC_BUS2: begin
                raw = half_ff;
                ok = (cv.power_mode == PM_RUN) || (cv.power_mode == PM_WAIT);
            end
            SRC_ALT: begin
                raw = alt_ff[1] & ~alt_ff[2];
                ok = (cv.power_mode == PM_RUN) || (cv.power_mode == PM_WAIT);
            end
            default: begin
                raw = asy_ff[1] & ~asy_ff[2];
                ok = cv.power_mode != PM_STOP2;
            end
        endcase
        case (cv.div_sel)
            2'h0: lim = 3'h0;
            2'h1: lim = 3'h1;
            2'h2: lim = 3'h3;
            default: lim = 3'h7;
        endcase
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (raw && ok) begin
            nxt_tick = cnt_ff >= lim;
            nxt_cnt = (cnt_ff >= lim) ? 3'h0 : cnt_ff + 3'h1;
        end
    end

    // Registers only
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alt_ff <= 3'h0;
            asy_ff <= 3'h0;
            cnt_ff <= 3'h0;
            half_ff <= 1'b0;
            tick_ff <= 1'b0;
        end else begin
            alt_ff <= nxt_alt;
            asy_ff <= nxt_asy;
            cnt_ff <= nxt_cnt;
            half_ff <= nxt_half;
            tick_ff <= nxt_tick;
        end
    end
    assign cv.tick = tick_ff;

    alt_stop_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (cv.src_sel == SRC_ALT && cv.power_mode[1]) |=> !cv.tick)
        else $error("alternate clock ticked in stop");
endmodule

/* File: rtl/sar_engine.sv */
// Successive approximation sequencer: sample phase then one bit per tick
// Assumes comp_hi settles within one mclk of a dac change
`timescale 1ns/1ps
module sar_engine
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_sync_n,
    // Control side
    conv_if.engine cv
);
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_SAMPLE = 3'b010, ST_CONV = 3'b100} sar_state_e;
    sar_state_e state_ff, nxt_state;
    logic [4:0] cnt_ff, nxt_cnt, last;
    logic [9:0] sar_ff, nxt_sar, res_ff, nxt_res, trial;
    logic done_ff, nxt_done;

    // Start restarts even a busy engine, so an abort with start is a restart
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sar = sar_ff;
        nxt_res = res_ff;
        nxt_done = 1'b0;
        trial = sar_ff;
        trial[cnt_ff[3:0]] = cv.comp_hi;
        last = (cv.long_sample ? SAMPLE_LONG_CYC : SAMPLE_SHORT_CYC) - 5'h01;
        if (cv.start) begin
            nxt_state = ST_SAMPLE;
            nxt_cnt = 5'h00;
            nxt_sar = 10'h000;
        end else if (cv.abort) begin
            nxt_state = ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: nxt_state = ST_IDLE;
                ST_SAMPLE: if (cv.tick) begin
                    nxt_cnt = (cnt_ff == last) ? RES_BITS - 5'h01 : cnt_ff + 5'h01;
                    nxt_sar = (cnt_ff == last) ? 10'h200 : sar_ff;
                    nxt_state = (cnt_ff == last) ? ST_CONV : ST_SAMPLE;
                end
                ST_CONV: if (cv.tick) begin
                    nxt_sar = trial;
                    if (cnt_ff == 5'h00) begin
                        nxt_res = trial;
                        nxt_done = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_sar[cnt_ff[3:0] - 4'h1] = 1'b1;
                        nxt_cnt = cnt_ff - 5'h01;
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 5'h00;
            sar_ff <= 10'h000;
            res_ff <= 10'h000;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sar_ff <= nxt_sar;
            res_ff <= nxt_res;
            done_ff <= nxt_done;
        end
    end
    assign cv.busy = state_ff != ST_IDLE;
    assign cv.done = done_ff;
    assign cv.result = res_ff;
    assign cv.dac = sar_ff;

    idle_after_a: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        (cv.done && !$past(cv.start)) |-> state_ff == ST_IDLE)
        else $error("engine not idle after completion");
endmodule

/* File: test/analog_front_model.sv */
// Comparator model for the analog front end
// Assumes an ideal input level held steady for the whole conversion
`timescale 1ns/1ps
module analog_front_model (
    // Trial word and input level
    input wire logic [9:0] dac_code,
    input wire logic [9:0] vin,
    // Comparator output
    output logic comp_hi
);
    // High keeps the trial bit, so an ideal search lands on vin exactly
    assign comp_hi = (vin >= dac_code);
endmodule

/* File: test/sar_adc_channel_trigger_control_tb.sv */
// Bench for the converter control block with an ideal comparator
// Assumes free-running slow clock pins; the slowest conversion takes tens of microseconds
`timescale 1ns/1ps
module sar_adc_channel_trigger_control_tb;
import adc_ctrl_pkg::*;
logic mclk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, hw_trigger_input = 0;
logic bandgap_buffer_enable = 1, alternate_clock = 0, local_async_conv_clock = 0;
logic [2:0] addr = 0;
logic [7:0] wdata = 0, rdata, d;
logic [1:0] power_mode = 0;
logic comp_hi, gnd_sel, temp_sel, bandgap_sel, refh_sel, refl_sel, conv_power;
logic low_power_bias, irq;
logic [9:0] dac_code, vin = 0;
logic [11:0] pin_sel;
int fails = 0, total_checks = 0, seed = 38592;
always #2 mclk = ~mclk;
// Slow clock pins, both well under a quarter of mclk
always #20 alternate_clock = ~alternate_clock;
always #500 local_async_conv_clock = ~local_async_conv_clock;
adc_trigger_ctrl dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .power_mode(power_mode),
    .bandgap_buffer_enable(bandgap_buffer_enable), .hw_trigger_input(hw_trigger_input),
    .alternate_clock(alternate_clock), .local_async_conv_clock(local_async_conv_clock),
    .comp_hi(comp_hi), .dac_code(dac_code), .pin_sel(pin_sel), .gnd_sel(gnd_sel),
    .temp_sel(temp_sel), .bandgap_sel(bandgap_sel), .refh_sel(refh_sel), .refl_sel(refl_sel),
    .conv_power(conv_power), .low_power_bias(low_power_bias), .irq(irq));
analog_front_model afe (.dac_code(dac_code), .vin(vin), .comp_hi(comp_hi));
task end_of_test;
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk(input string n, input logic [16:0] g, input logic [16:0] e);
    total_checks++;
    if (g !== e) begin
        fails++;
        $display("wrong value %s exp %h got %h", n, e, g);
    end
endtask
task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk); addr <= a; wdata <= v; wr_stb <= 1;
    @(posedge mclk); wr_stb <= 0;
endtask
// Read data stand only in the cycle after the strobe
task rd(input logic [2:0] a);
    @(posedge mclk); addr <= a; rd_stb <= 1;
    @(posedge mclk); rd_stb <= 0;
    #1 d = rdata;
endtask
// Poll the flag with a bound so a lost conversion cannot hang the run
task wait_done;
    d = 0;
    for (int i = 0; i < 6000 && d[7] !== 1'b1; i++) rd(OFS_CTRL1);
endtask
task idle_flag(input string n);
    repeat (150) @(posedge mclk);
    rd(OFS_CTRL1);
    chk(n, d[7], 0);
endtask
// Overflow pulse held well past the two-stage synchroniser
task pulse_trig;
    hw_trigger_input <= 1;
    repeat (4) @(posedge mclk);
    hw_trigger_input <= 0;
endtask
task conv(input logic [7:0] cfg, input logic [9:0] e, input logic [4:0] ch);
    wr(OFS_CFG, cfg);
    wr(OFS_CTRL1, {3'b010, ch});
    @(posedge mclk) #1 chk("pwr_on", conv_power, 1);
    wait_done;
    @(posedge mclk) #1 chk("irq", irq, 1);
    rd(OFS_RESH); chk("resh", d, e[9:8]);
    rd(OFS_RESL); chk("resl", d, e[7:0]);
    rd(OFS_CTRL1); chk("flag", d[7], 0);
endtask
initial begin
    #300000 fails++;
    end_of_test;
end
initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    repeat (3) @(posedge mclk);
    rd(OFS_CTRL1); chk("ctrl1", d, CTRL1_RST);
    rd(OFS_CFG); chk("cfg", d, CFG_RST);
    rd(3'h7); chk("unmapped", d, 0);
    chk("rst_out", {irq, conv_power, pin_sel}, 0);
    wr(OFS_CFG, 8'h80);
    #1 chk("lowpwr", low_power_bias, 1);
    // Every channel code, reserved ones routing nothing
    for (int c = 0; c < 32; c++) begin
        wr(OFS_CTRL1, 8'(c));
        repeat (2) @(posedge mclk);
        #1 chk("route", {pin_sel, gnd_sel, temp_sel, bandgap_sel, refh_sel, refl_sel},
            {12'(c < 12 ? 1 << c : 0), c >= 12 && c <= 20, c == 26, c == 27, c == 29,
            c == 30});
    end
    chk("power", conv_power, 0);
    // Bandgap stays isolated without its buffer enable
    @(posedge mclk) bandgap_buffer_enable <= 0;
    wr(OFS_CTRL1, 8'(CH_BG));
    repeat (2) @(posedge mclk);
    #1 chk("bg_off", bandgap_sel, 0);
    @(posedge mclk) bandgap_buffer_enable <= 1;
    // Every divider setting, pin, ground and reserved codes alike
    for (int k = 0; k < 4; k++) begin
        vin = $random(seed);
        conv(8'(4 + (k & 1) + (k << 5)), vin, 5'(k * 7));
        conv(8'((k & 1) + (k << 5)), vin >> 2, 5'(k * 7));
    end
    // Compare against vin + 1: greater-or-equal fails, less-than holds
    vin = $random(seed) & 10'h3fe;
    wr(OFS_CMPH, 8'((vin + 1) >> 8));
    wr(OFS_CMPL, 8'(vin + 1));
    wr(OFS_CTRL2, 8'h30);
    wr(OFS_CFG, 8'h04);
    wr(OFS_CTRL1, 8'h00);
    idle_flag("cmp_ge");
    wr(OFS_CTRL2, 8'h20);
    conv(8'h04, vin, 5'h00);
    // Equal value: greater-or-equal holds
    wr(OFS_CMPL, 8'(vin));
    wr(OFS_CMPH, 8'(vin >> 8));
    wr(OFS_CTRL2, 8'h30);
    conv(8'h04, vin, 5'h00);
    // Hardware mode waits for the overflow pulse
    wr(OFS_CTRL2, 8'h40);
    wr(OFS_CTRL1, 8'h40);
    idle_flag("hw_wait");
    pulse_trig;
    wait_done;
    chk("hw_done", d[7], 1);
    // Continuous runs until the all-ones code stops it
    wr(OFS_CTRL2, 8'h00);
    wr(OFS_CTRL1, 8'h20);
    wait_done;
    rd(OFS_RESL);
    wait_done;
    chk("cont", d[7], 1);
    wr(OFS_CTRL1, 8'h3f);
    // A finish in the write cycle itself still sets the flag, so clear it once
    rd(OFS_RESL);
    idle_flag("off");
    chk("off_pwr", conv_power, 0);
    // Alternate clock converts in wait, gives no ticks in shallow stop
    vin = $random(seed);
    @(posedge mclk) power_mode <= PM_WAIT;
    conv(8'h06, vin, 5'h00);
    @(posedge mclk) power_mode <= PM_STOP3;
    wr(OFS_CTRL1, 8'h00);
    idle_flag("alt_stop");
    // Temperature: long sample on the 1 MHz local clock, bandgap before sensor
    conv(8'h17, vin, CH_BG);
    conv(8'h17, vin, CH_TEMP);
    // Overflow trigger still starts conversions in shallow stop
    wr(OFS_CTRL2, 8'h40);
    wr(OFS_CTRL1, 8'h40);
    pulse_trig;
    wait_done;
    chk("hw_stop3", d[7], 1);
    end_of_test;
end
endmodule
